// ---- src/sramc_pkg.sv ----
// Package: timing constants and pin encodings for the asynchronous SRAM controller
package sramc_pkg;
    localparam int          CLK_PERIOD_NS  = 20;
    localparam int          ADDR_W         = 16;
    localparam int          DATA_W         = 16;
    localparam int          LANE_W         = 8;
    // Slowest speed grade figures, in ns
    localparam int          READ_CYCLE_NS  = 20;
    localparam int          ACCESS_NS      = 20;
    localparam int          WRITE_CYCLE_NS = 20;
    localparam int          WRITE_PULSE_NS = 12;
    localparam int          FLOAT_NS       = 8;
    localparam int          DATA_SETUP_NS  = 10;
    // Least times round up, at least one cycle
    localparam int          ACCESS_CYC     = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int          WP_RAW         = FLOAT_NS + DATA_SETUP_NS > WRITE_PULSE_NS ?
                                             FLOAT_NS + DATA_SETUP_NS : WRITE_PULSE_NS;
    localparam int          WRITE_CYC      = (WP_RAW + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          FLOAT_CYC      = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RC_CYC         = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          WC_CYC         = (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W          = 4;
    localparam logic [CNT_W-1:0] ACCESS_CNT = CNT_W'(ACCESS_CYC);
    localparam logic [CNT_W-1:0] WRITE_CNT  = CNT_W'(WRITE_CYC);
    localparam logic [CNT_W-1:0] FLOAT_CNT  = CNT_W'(FLOAT_CYC);
    localparam logic [CNT_W-1:0] RC_CNT     = CNT_W'(RC_CYC);
    localparam logic [CNT_W-1:0] WC_CNT     = CNT_W'(WC_CYC);
    localparam logic [1:0]  LANES_OFF      = 2'h3;
    typedef enum logic [5:0] {
        SRAMC_IDLE   = 6'h01,
        SRAMC_RD     = 6'h02,
        SRAMC_RD_END = 6'h04,
        SRAMC_WR_SET = 6'h08,
        SRAMC_WR     = 6'h10,
        SRAMC_REC    = 6'h20
    } sramc_state_t;
endpackage

// ---- src/sramc_ctrl.sv ----
// Controller that drives a 64K x 16 asynchronous SRAM through its pins
// Contract
// - Output enable low: pulse covers float plus setup
// - Output enable high: pulse may be plain minimum
// - Never drive data while memory drives
// - Address valid before select and lanes fall; reads drop select on the same edge as the address goes out
// - Write enable high through every read
// - Address valid long enough before write end
// - Select low long enough before write end
// - Lanes low long enough before write end
// - Address stable through the whole write
// - Data valid before write end, held after
`timescale 1ns/1ps
module sramc_ctrl (
    // Clock and reset
    input  wire logic                           clock_i,
    input  wire logic                           rst_n_i,
    // User request
    input  wire logic                           req_i,
    input  wire logic                           req_write_i,
    input  wire logic [sramc_pkg::ADDR_W-1:0]   req_addr_i,
    input  wire logic [sramc_pkg::DATA_W-1:0]   req_wdata_i,
    input  wire logic [1:0]                     req_lane_n_i,
    output logic                                busy_o,
    output logic                                rd_valid_o,
    output logic [sramc_pkg::DATA_W-1:0]        rd_data_o,
    // Memory pins
    output logic [sramc_pkg::ADDR_W-1:0]        word_address_o,
    output logic                                chip_select_n_o,
    output logic                                output_enable_n_o,
    output logic                                write_enable_n_o,
    output logic                                upper_lane_enable_n_o,
    output logic                                lower_lane_enable_n_o,
    input  wire logic [sramc_pkg::DATA_W-1:0]   data_bus_i,
    output logic [sramc_pkg::DATA_W-1:0]        data_bus_o,
    output logic                                data_bus_oe_n_o
);
    sramc_pkg::sramc_state_t state;
    sramc_pkg::sramc_state_t next_state;
    logic [sramc_pkg::CNT_W-1:0]   cnt;
    logic [sramc_pkg::CNT_W-1:0]   next_cnt;
    logic [sramc_pkg::DATA_W-1:0]  bus_meta;
    logic [sramc_pkg::DATA_W-1:0]  bus_sync;
    logic [1:0]                    rd_lane_n;

    // Data pins are asynchronous to us: two flops before use
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            bus_meta <= '0;
            bus_sync <= '0;
        end else begin
            bus_meta <= data_bus_i;
            bus_sync <= bus_meta;
        end
    end

    always_comb begin
        next_state = state;
        next_cnt   = (cnt != '0) ? cnt - 1'b1 : cnt;
        unique case (state)
            sramc_pkg::SRAMC_IDLE: begin
                if (req_i && req_lane_n_i != sramc_pkg::LANES_OFF) begin
                    // Write first floats the bus a cycle with strobes high
                    next_state = req_write_i ? sramc_pkg::SRAMC_WR_SET : sramc_pkg::SRAMC_RD;
                    next_cnt   = req_write_i ? sramc_pkg::WRITE_CNT : sramc_pkg::ACCESS_CNT;
                end
            end
            sramc_pkg::SRAMC_RD: begin
                // Hold strobes through access time plus sync delay
                if (cnt == '0) begin
                    next_state = sramc_pkg::SRAMC_RD_END;
                end
            end
            sramc_pkg::SRAMC_RD_END: begin
                next_state = sramc_pkg::SRAMC_REC;
                next_cnt   = sramc_pkg::FLOAT_CNT;
            end
            sramc_pkg::SRAMC_WR_SET: begin
                next_state = sramc_pkg::SRAMC_WR;
            end
            sramc_pkg::SRAMC_WR: begin
                // Pulse covers float plus setup even with enable high
                if (cnt == '0) begin
                    next_state = sramc_pkg::SRAMC_REC;
                    next_cnt   = sramc_pkg::FLOAT_CNT;
                end
            end
            sramc_pkg::SRAMC_REC: begin
                // Gap lets memory float before next access
                if (cnt == '0) begin
                    next_state = sramc_pkg::SRAMC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state <= sramc_pkg::SRAMC_IDLE;
            cnt   <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // Address and write data latched at acceptance, stable through access
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            word_address_o <= '0;
            data_bus_o     <= '0;
            rd_lane_n      <= sramc_pkg::LANES_OFF;
        end else if (state == sramc_pkg::SRAMC_IDLE && req_i) begin
            word_address_o <= req_addr_i;
            data_bus_o     <= req_wdata_i;
            rd_lane_n      <= req_lane_n_i;
        end
    end

    // Strobes: for writes select and lanes fall a cycle after address is out; for reads select falls on the same edge with prior lanes, new a cycle later
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            chip_select_n_o       <= 1'b1;
            upper_lane_enable_n_o <= 1'b1;
            lower_lane_enable_n_o <= 1'b1;
            output_enable_n_o     <= 1'b1;
        end else begin
            chip_select_n_o       <= !(next_state == sramc_pkg::SRAMC_RD ||
                                       next_state == sramc_pkg::SRAMC_WR);
            upper_lane_enable_n_o <= (next_state == sramc_pkg::SRAMC_RD ||
                                      next_state == sramc_pkg::SRAMC_WR) ?
                                     rd_lane_n[1] : 1'b1;
            lower_lane_enable_n_o <= (next_state == sramc_pkg::SRAMC_RD ||
                                      next_state == sramc_pkg::SRAMC_WR) ?
                                     rd_lane_n[0] : 1'b1;
            output_enable_n_o     <= !(next_state == sramc_pkg::SRAMC_RD);
        end
    end

    // Write enable only in write pulse, high through reads
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            write_enable_n_o <= 1'b1;
        end else begin
            write_enable_n_o <= !(next_state == sramc_pkg::SRAMC_WR);
        end
    end

    // Drive bus while write strobes stand and one cycle after; data held past write end
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            data_bus_oe_n_o <= 1'b1;
        end else begin
            data_bus_oe_n_o <= !(next_state == sramc_pkg::SRAMC_WR ||
                                 (state == sramc_pkg::SRAMC_WR &&
                                  next_state == sramc_pkg::SRAMC_REC));
        end
    end

    // Capture synchronised read data at end of access, unused lanes zero
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rd_valid_o   <= 1'b0;
            rd_data_o    <= '0;
        end else begin
            rd_valid_o   <= (state == sramc_pkg::SRAMC_RD_END);
            if (state == sramc_pkg::SRAMC_RD_END) begin
                rd_data_o <= {rd_lane_n[1] ? 8'h00 : bus_sync[15:8],
                              rd_lane_n[0] ? 8'h00 : bus_sync[7:0]};
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            busy_o <= 1'b1;
        end else begin
            busy_o <= (next_state != sramc_pkg::SRAMC_IDLE);
        end
    end
endmodule

// ---- bench/sramc_mem.sv ----
// Behavioural model of the 64K x 16 asynchronous memory at its pins
`timescale 1ns/1ps
module sramc_mem (
    // Address and strobes
    input  wire logic [15:0] word_address_i,
    input  wire logic        chip_select_n_i,
    input  wire logic        output_enable_n_i,
    input  wire logic        write_enable_n_i,
    input  wire logic [1:0]  lane_n_i,
    // Shared data bus
    input  wire logic [15:0] data_bus_i,
    output logic      [15:0] data_bus_o
);
    logic [15:0] cells [0:65535];
    logic [15:0] drv;
    // Released lanes show the inverse, so a stale value never passes as read data
    assign drv = {{8{!lane_n_i[1]}}, {8{!lane_n_i[0]}}}
        & {16{!chip_select_n_i && !output_enable_n_i && write_enable_n_i}};
    // No hold after an address change: worst case for the controller
    assign data_bus_o = (cells[word_address_i] & drv) | (~cells[word_address_i] & ~drv);
    always @* begin
        if (!chip_select_n_i && !write_enable_n_i) begin
            if (!lane_n_i[0]) cells[word_address_i][7:0] = data_bus_i[7:0];
            if (!lane_n_i[1]) cells[word_address_i][15:8] = data_bus_i[15:8];
        end
    end
endmodule

// ---- bench/sramc_monitor.sv ----
// Pin protocol checks for the SRAM controller
`timescale 1ns/1ps
module sramc_monitor (
    // Clock and reset
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    // Watched outputs
    input wire logic        busy_o,
    input wire logic        rd_valid_o,
    input wire logic [15:0] word_address_o,
    input wire logic        chip_select_n_o,
    input wire logic        output_enable_n_o,
    input wire logic        write_enable_n_o,
    input wire logic        upper_lane_enable_n_o,
    input wire logic        lower_lane_enable_n_o,
    input wire logic [15:0] data_bus_o,
    input wire logic        data_bus_oe_n_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_no_bus_fight: assert property (!data_bus_oe_n_o |-> output_enable_n_o)
        else $error("bus fight");
    a_read_we_high: assert property (!output_enable_n_o |-> write_enable_n_o && !chip_select_n_o)
        else $error("read strobes");
    a_read_timing: assert property ($fell(output_enable_n_o) |-> ##1 (!output_enable_n_o && $stable(word_address_o))[*2] ##1 output_enable_n_o ##1 rd_valid_o)
        else $error("read timing");
    a_write_start: assert property ($fell(write_enable_n_o) |-> $fell(chip_select_n_o) && $stable(word_address_o) && $stable(data_bus_o))
        else $error("write start");
    a_write_strobes: assert property (!write_enable_n_o |-> output_enable_n_o && !data_bus_oe_n_o && !(upper_lane_enable_n_o && lower_lane_enable_n_o))
        else $error("write strobes");
    a_write_end: assert property ($fell(write_enable_n_o) |=> write_enable_n_o && chip_select_n_o && !data_bus_oe_n_o && $stable(data_bus_o) && $stable(word_address_o))
        else $error("write end");
    a_bus_release: assert property ($rose(write_enable_n_o) |=> data_bus_oe_n_o)
        else $error("bus not released");
    a_valid_pulse: assert property (rd_valid_o |=> !rd_valid_o ##1 !busy_o)
        else $error("valid pulse");
    c_read: cover property ($fell(output_enable_n_o));
    c_upper_write: cover property ($fell(write_enable_n_o) && lower_lane_enable_n_o);
    c_lower_write: cover property ($fell(write_enable_n_o) && upper_lane_enable_n_o);
endmodule
bind sramc_ctrl sramc_monitor u_mon (.clock_i, .rst_n_i, .busy_o, .rd_valid_o, .word_address_o,
    .chip_select_n_o, .output_enable_n_o, .write_enable_n_o, .upper_lane_enable_n_o,
    .lower_lane_enable_n_o, .data_bus_o, .data_bus_oe_n_o);

// ---- bench/sramc_ctrl_tb.sv ----
// Self-checking bench for the SRAM controller against a memory model
`timescale 1ns/1ps
module sramc_ctrl_tb;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        req_i = 1'b0;
    logic        req_write_i = 1'b0;
    logic [15:0] req_addr_i = 16'h0000;
    logic [15:0] req_wdata_i = 16'h0000;
    logic [1:0]  req_lane_n_i = 2'h3;
    logic        busy_o, rd_valid_o, cs_n, oe_n, we_n, ub_n, lb_n, bus_oe_n;
    logic [15:0] rd_data_o, addr, bus_out, mem_out, bus;
    logic [15:0] shadow [0:7];
    int          mismatches = 0;
    int          compares = 0;
    int          cycles = 0;
    assign bus = bus_oe_n ? mem_out : bus_out;
    sramc_ctrl u_dut (.clock_i, .rst_n_i, .req_i, .req_write_i, .req_addr_i, .req_wdata_i,
        .req_lane_n_i, .busy_o, .rd_valid_o, .rd_data_o, .word_address_o(addr),
        .chip_select_n_o(cs_n), .output_enable_n_o(oe_n), .write_enable_n_o(we_n),
        .upper_lane_enable_n_o(ub_n), .lower_lane_enable_n_o(lb_n), .data_bus_i(bus),
        .data_bus_o(bus_out), .data_bus_oe_n_o(bus_oe_n));
    sramc_mem u_mem (.word_address_i(addr), .chip_select_n_i(cs_n), .output_enable_n_i(oe_n),
        .write_enable_n_i(we_n), .lane_n_i({ub_n, lb_n}), .data_bus_i(bus), .data_bus_o(mem_out));
    initial forever #10 clock_i = ~clock_i;
    task automatic close_out();
        $display("Compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] lane_mask(input logic [1:0] ln);
        return {{8{!ln[1]}}, {8{!ln[0]}}};
    endfunction
    // One access; lanes 11 is expected to be ignored
    task automatic op(input logic wr, input int i, input logic [15:0] d, input logic [1:0] ln);
        logic [15:0] exp;
        logic        got;
        exp = shadow[i] & lane_mask(ln);
        got = 1'b0;
        @(negedge clock_i);
        req_i = 1'b1;
        req_write_i = wr;
        req_addr_i = (i == 7) ? 16'hFFFF : 16'(i) * 16'h1111;
        req_wdata_i = d;
        req_lane_n_i = ln;
        @(negedge clock_i);
        req_i = 1'b0;
        for (int n = 0; n < 3 && busy_o !== 1'b1; n++) @(negedge clock_i);
        check(16'(busy_o), 16'(ln != 2'h3));
        for (int n = 0; n < 12 && busy_o !== 1'b0; n++) begin
            @(negedge clock_i);
            if (rd_valid_o === 1'b1) begin
                got = 1'b1;
                check(rd_data_o, exp);
            end
        end
        check(16'(busy_o), 16'h0000);
        if (!wr && ln != 2'h3) check(16'(got), 16'h0001);
        if (wr && ln != 2'h3) shadow[i] = (shadow[i] & ~lane_mask(ln)) | (d & lane_mask(ln));
    endtask
    initial begin
        void'($urandom(32'h9FFE0D5E));
        repeat (10) @(negedge clock_i);
        rst_n_i = 1'b1;
        for (int i = 0; i < 8; i++) op(1'b1, i, 16'($urandom), 2'h0);
        for (int i = 0; i < 8; i++) op(1'b0, i, 16'h0000, 2'h0);
        op(1'b1, 7, 16'hA55A, 2'h1);
        op(1'b0, 7, 16'h0000, 2'h2);
        op(1'b1, 0, 16'hFFFF, 2'h3);
        op(1'b0, 0, 16'h0000, 2'h0);
        for (int k = 0; k < 80; k++) op(1'($urandom), $urandom % 8, 16'($urandom), 2'($urandom));
        close_out();
    end
endmodule
